/* File: logic/lbae_alu.sv */
// combinational arithmetic, logic and bit unit
`default_nettype none
module lbae_alu
   import lbae_pkg::*;
(
   lbae_alu_if.alu a
);
   logic [4:0] low_sum;
   logic [8:0] full_sum;
   logic [7:0] mask;
   always_comb
   begin
      low_sum = {1'b0, a.acc[3:0]} + {1'b0, a.opnd[3:0]};
      full_sum = {1'b0, a.acc} + {1'b0, a.opnd};
      mask = 8'h01 << a.bit_sel;
      a.carry = 1'b0;
      a.nibble = 1'b0;
      a.skip = 1'b0;
      case (a.kind)
         LBAE_K_ADD:
         begin
            a.result = full_sum[7:0];
            a.carry = full_sum[8];
            a.nibble = low_sum[4];
         end
         LBAE_K_AND: a.result = a.acc & a.opnd;
         LBAE_K_ANDLIT: a.result = a.acc & a.lit;
         LBAE_K_MOVE: a.result = a.opnd;
         LBAE_K_BIT:
         begin
            a.result = a.bit_set ? (a.opnd | mask) : (a.opnd & ~mask);
         end
         LBAE_K_TEST:
         begin
            a.result = a.opnd;
            a.skip = (a.opnd[a.bit_sel] == a.skip_on_high);
         end
         default: a.result = a.acc;
      endcase
      a.zero = (a.result == 8'h00);
   end
endmodule
`default_nettype wire

/* File: logic/lbae_alu_if.sv */
// interface carrying alu operands and results between top and alu
`default_nettype none
interface lbae_alu_if;
   import lbae_pkg::*;
   lbae_kind_t kind;
   logic [7:0] acc;
   logic [7:0] opnd;
   logic [7:0] lit;
   logic [2:0] bit_sel;
   logic bit_set;
   logic skip_on_high;
   logic [7:0] result;
   logic carry;
   logic nibble;
   logic zero;
   logic skip;
   modport top (output kind, acc, opnd, lit, bit_sel, bit_set,
      skip_on_high, input result, carry, nibble, zero, skip);
   modport alu (input kind, acc, opnd, lit, bit_sel, bit_set,
      skip_on_high, output result, carry, nibble, zero, skip);
endinterface
`default_nettype wire

/* File: logic/lbae_exec.sv */
// execute stage: decode, register file, pin port and skip logic
`default_nettype none
module lbae_exec
   import lbae_pkg::*;
#(
   parameter int NUM_REGS = 32
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [11:0] instr_word,
   input wire logic presc_to_timer,
   input wire logic timer_tick,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_n,
   output logic [7:0] acc_value,
   output logic [7:0] status_value,
   output logic [7:0] timer_value,
   output logic [7:0] presc_value,
   output logic skip_req,
   output logic exec_busy
);
   // refused at elaboration: fewer than eight or more than 32 words
   if (NUM_REGS < 8 || NUM_REGS > 32)
   begin
      $error("NUM_REGS must be 8..32");
   end

   lbae_alu_if alu_bus ();
   lbae_alu u_alu (.a(alu_bus));

   logic [7:0] pin_s1_reg, pin_s2_reg;
   logic [7:0] acc_reg, acc_next;
   logic [7:0] dir_reg, dir_next;
   logic [7:0] latch_reg, latch_next;
   logic [7:0] timer_reg, timer_next;
   logic [7:0] presc_reg, presc_next;
   logic [7:0] status_reg, status_next;
   logic skip_reg, skip_next;
   logic flush_reg, flush_next;
   logic [7:0] gp_reg [NUM_REGS];
   logic gp_we;
   logic [4:0] gp_addr;
   logic [7:0] gp_wdata;

   logic [4:0] f_addr;
   logic dest_reg_sel;
   logic [7:0] f_read;
   logic f_write;
   logic go;
   lbae_kind_t kind;

   assign f_addr = instr_word[4:0];
   assign dest_reg_sel = instr_word[5];
   // the word after a taken skip is executed as a no-op
   assign go = instr_valid && !flush_reg;

   always_comb
   begin
      kind = LBAE_K_NONE;
      if (go)
      begin
         if (instr_word[11:6] == LBAE_OP_ADD)
            kind = LBAE_K_ADD;
         else if (instr_word[11:6] == LBAE_OP_AND)
            kind = LBAE_K_AND;
         else if (instr_word[11:6] == LBAE_OP_MOVE)
            kind = LBAE_K_MOVE;
         else if (instr_word[11:8] == LBAE_OP_ANDLIT)
            kind = LBAE_K_ANDLIT;
         else if (instr_word[11:8] == LBAE_OP_BCLR ||
                  instr_word[11:8] == LBAE_OP_BSET)
            kind = LBAE_K_BIT;
         else if (instr_word[11:8] == LBAE_OP_BTLOW ||
                  instr_word[11:8] == LBAE_OP_BTHIGH)
            kind = LBAE_K_TEST;
         else if (instr_word[11:3] == LBAE_OP_LDDIR &&
                  instr_word[2:1] != LBAE_LDDIR_TAG)
            kind = LBAE_K_LDDIR;
      end
   end

   // operand fetch; the port reads pins so external lows are written back
   always_comb
   begin
      case (f_addr)
         LBAE_ADDR_TIMER: f_read = timer_reg;
         LBAE_ADDR_STATUS: f_read = status_reg;
         LBAE_ADDR_PORT: f_read = pin_s2_reg;
         default: f_read = (32'(f_addr) < NUM_REGS) ? gp_reg[f_addr] : 8'h00;
      endcase
   end

   assign alu_bus.kind = kind;
   assign alu_bus.acc = acc_reg;
   assign alu_bus.opnd = f_read;
   assign alu_bus.lit = instr_word[7:0];
   assign alu_bus.bit_sel = instr_word[7:5];
   assign alu_bus.bit_set = instr_word[8];
   assign alu_bus.skip_on_high = instr_word[8];

   always_comb
   begin
      acc_next = acc_reg;
      dir_next = dir_reg;
      latch_next = latch_reg;
      status_next = status_reg;
      timer_next = timer_reg + {7'h00, timer_tick};
      // ticks count even when the same word writes another register
      presc_next = presc_reg + {7'h00, presc_to_timer & timer_tick};
      skip_next = 1'b0;
      flush_next = 1'b0;
      f_write = 1'b0;
      case (kind)
         LBAE_K_ADD, LBAE_K_AND, LBAE_K_MOVE:
         begin
            if (dest_reg_sel)
               f_write = 1'b1;
            else
               acc_next = alu_bus.result;
         end
         LBAE_K_ANDLIT: acc_next = alu_bus.result;
         LBAE_K_BIT: f_write = 1'b1;
         LBAE_K_TEST:
         begin
            skip_next = alu_bus.skip;
            // no flush when the bit fails, the prefetched word runs next
            flush_next = alu_bus.skip;
         end
         LBAE_K_LDDIR:
         begin
            if (instr_word[2:0] == LBAE_DIR_PORT_SEL)
               dir_next = acc_reg;
         end
         default: acc_next = acc_reg;
      endcase
      case (kind)
         LBAE_K_ADD:
         begin
            status_next[LBAE_ST_CARRY] = alu_bus.carry;
            status_next[LBAE_ST_NIBBLE] = alu_bus.nibble;
            status_next[LBAE_ST_ZERO] = alu_bus.zero;
         end
         LBAE_K_AND, LBAE_K_ANDLIT, LBAE_K_MOVE:
            status_next[LBAE_ST_ZERO] = alu_bus.zero;
         default: status_next = status_reg;
      endcase
      if (f_write)
      begin
         case (f_addr)
            LBAE_ADDR_TIMER:
            begin
               timer_next = alu_bus.result;
               if (presc_to_timer)
                  presc_next = LBAE_PRESC_RESET;
            end
            // flags from this instruction win over a plain write; a bit
            // op has no flags of its own, so its whole result lands
            LBAE_ADDR_STATUS:
            begin
               case (kind)
                  LBAE_K_ADD:
                     status_next = {alu_bus.result[7:3], status_next[2:0]};
                  LBAE_K_BIT:
                     status_next = alu_bus.result;
                  default:
                     status_next = {alu_bus.result[7:3], status_next[2],
                        alu_bus.result[1:0]};
               endcase
            end
            LBAE_ADDR_PORT: latch_next = alu_bus.result;
            default: latch_next = latch_reg;
         endcase
      end
   end

   assign gp_we = f_write && f_addr != LBAE_ADDR_TIMER &&
      f_addr != LBAE_ADDR_STATUS && f_addr != LBAE_ADDR_PORT &&
      32'(f_addr) < NUM_REGS;
   assign gp_addr = f_addr;
   assign gp_wdata = alu_bus.result;

   // general registers have no reset, as in ordinary file ram
   always_ff @(posedge clk_sys)
   begin
      if (gp_we)
         gp_reg[gp_addr] <= gp_wdata;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_reg <= 8'h00;
         pin_s2_reg <= 8'h00;
         acc_reg <= LBAE_ACC_RESET;
         dir_reg <= LBAE_DIR_RESET;
         latch_reg <= LBAE_LATCH_RESET;
         timer_reg <= LBAE_TIMER_RESET;
         presc_reg <= LBAE_PRESC_RESET;
         status_reg <= LBAE_STATUS_RESET;
         skip_reg <= 1'b0;
         flush_reg <= 1'b0;
         pin_out <= LBAE_LATCH_RESET;
         pin_oe_n <= LBAE_DIR_RESET;
      end
      else
      begin
         pin_s1_reg <= pin_in;
         pin_s2_reg <= pin_s1_reg;
         acc_reg <= acc_next;
         dir_reg <= dir_next;
         latch_reg <= latch_next;
         timer_reg <= timer_next;
         presc_reg <= presc_next;
         status_reg <= status_next;
         skip_reg <= skip_next;
         flush_reg <= flush_next;
         pin_out <= latch_next;
         pin_oe_n <= dir_next;
      end
   end

   assign acc_value = acc_reg;
   assign status_value = status_reg;
   assign timer_value = timer_reg;
   assign presc_value = presc_reg;
   assign skip_req = skip_reg;
   assign exec_busy = flush_reg;
endmodule
`default_nettype wire

/* File: logic/lbae_pkg.sv */
// package: opcodes, register addresses, status bit positions for lbae block
`default_nettype none
package lbae_pkg;
   localparam int LBAE_DATA_W = 8;
   localparam int LBAE_ADDR_W = 5;
   // register addresses inside the file space
   localparam logic [4:0] LBAE_ADDR_TIMER = 5'h01;
   localparam logic [4:0] LBAE_ADDR_STATUS = 5'h03;
   localparam logic [4:0] LBAE_ADDR_PORT = 5'h06;
   // operand of the load-direction instruction that selects the pin port
   localparam logic [2:0] LBAE_DIR_PORT_SEL = 3'h6;
   // status bit positions
   localparam int LBAE_ST_CARRY = 0;
   localparam int LBAE_ST_NIBBLE = 1;
   localparam int LBAE_ST_ZERO = 2;
   // reset values
   localparam logic [7:0] LBAE_ACC_RESET = 8'h00;
   localparam logic [7:0] LBAE_DIR_RESET = 8'hFF;
   localparam logic [7:0] LBAE_LATCH_RESET = 8'h00;
   localparam logic [7:0] LBAE_TIMER_RESET = 8'h00;
   localparam logic [7:0] LBAE_PRESC_RESET = 8'h00;
   localparam logic [7:0] LBAE_STATUS_RESET = 8'h18;
   // opcode fields, 12-bit instruction word
   localparam logic [5:0] LBAE_OP_ADD = 6'h07;
   localparam logic [5:0] LBAE_OP_AND = 6'h05;
   localparam logic [5:0] LBAE_OP_MOVE = 6'h08;
   localparam logic [3:0] LBAE_OP_ANDLIT = 4'hE;
   localparam logic [3:0] LBAE_OP_BCLR = 4'h4;
   localparam logic [3:0] LBAE_OP_BSET = 4'h5;
   localparam logic [3:0] LBAE_OP_BTLOW = 4'h6;
   localparam logic [3:0] LBAE_OP_BTHIGH = 4'h7;
   localparam logic [8:0] LBAE_OP_LDDIR = 9'h000;
   localparam logic [1:0] LBAE_LDDIR_TAG = 2'h0;
   typedef enum logic [2:0] {
      LBAE_K_NONE, LBAE_K_ADD, LBAE_K_AND, LBAE_K_MOVE, LBAE_K_ANDLIT,
      LBAE_K_BIT, LBAE_K_TEST, LBAE_K_LDDIR
   } lbae_kind_t;
endpackage
`default_nettype wire

/* File: testbench/lbae_exec_sva.sv */
// assertion checker for the lbae execute stage, bound to its top
`default_nettype none
module lbae_exec_sva
   import lbae_pkg::*;
#(
   parameter int NUM_REGS = 32
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [11:0] instr_word,
   input wire logic presc_to_timer,
   input wire logic timer_tick,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] acc_value,
   input wire logic [7:0] status_value,
   input wire logic [7:0] timer_value,
   input wire logic [7:0] presc_value,
   input wire logic skip_req,
   input wire logic exec_busy
);
   logic take;
   logic hit;
   logic nib;
   logic [2:0] bsel;
   logic [4:0] fsel;
   logic [7:0] lit;
   assign take = instr_valid && !exec_busy;
   assign bsel = instr_word[7:5];
   assign fsel = instr_word[4:0];
   assign lit = instr_word[7:0];
   // of the file registers, the timer and the status register have their values exposed on the ports, the port latch only as pin_out
   assign hit = timer_value[bsel] == instr_word[8];
   assign nib = ({1'b0, acc_value[3:0]} + {1'b0, timer_value[3:0]}) > 5'h0F;
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   AST_ADD_ACC:
   assert property (take && instr_word[11:5] == {LBAE_OP_ADD, 1'b0} &&
      fsel == LBAE_ADDR_TIMER |=> {status_value[LBAE_ST_CARRY], acc_value}
      == $past(acc_value) + $past(timer_value) && status_value[LBAE_ST_NIBBLE]
      == $past(nib) && status_value[LBAE_ST_ZERO] == (acc_value == 8'h00))
      else $error("add into accumulator wrong");
   AST_AND_REG:
   assert property (take && instr_word[11:5] == {LBAE_OP_AND, 1'b1} &&
      fsel == LBAE_ADDR_TIMER && presc_to_timer |=> timer_value ==
      ($past(acc_value) & $past(timer_value)) && presc_value == 8'h00 &&
      $stable(acc_value)) else $error("and into register wrong");
   AST_AND_LIT:
   assert property (take && instr_word[11:8] == LBAE_OP_ANDLIT |=>
      acc_value == ($past(acc_value) & $past(lit)) && $stable(status_value[1:0])
      && status_value[LBAE_ST_ZERO] == (acc_value == 8'h00))
      else $error("and literal wrong");
   AST_BIT_CLR:
   assert property (take && instr_word[11:8] == LBAE_OP_BCLR && !timer_tick &&
      fsel == LBAE_ADDR_TIMER |=> $stable(status_value) && timer_value ==
      ($past(timer_value) & ~(8'h01 << $past(bsel)))) else $error("bit clear");
   AST_BIT_SET:
   assert property (take && instr_word[11:8] == LBAE_OP_BSET && !timer_tick &&
      fsel == LBAE_ADDR_TIMER |=> $stable(status_value) && timer_value ==
      ($past(timer_value) | (8'h01 << $past(bsel)))) else $error("bit set");
   AST_SKIP_LOW:
   assert property (take && instr_word[11:8] == LBAE_OP_BTLOW && hit &&
      fsel == LBAE_ADDR_TIMER |=> skip_req && exec_busy &&
      $stable(status_value)) else $error("test low did not skip");
   AST_SKIP_HIGH:
   assert property (take && instr_word[11:8] == LBAE_OP_BTHIGH && hit &&
      fsel == LBAE_ADDR_TIMER |=> skip_req && exec_busy &&
      $stable(status_value)) else $error("test high did not skip");
   AST_NO_SKIP:
   assert property (take && instr_word[11:9] == 3'h3 && !hit &&
      fsel == LBAE_ADDR_TIMER |=> !skip_req && !exec_busy)
      else $error("skip without cause");
   AST_BUSY_ONE:
   assert property (exec_busy |-> skip_req ##1 !exec_busy)
      else $error("discard longer than one word");
   AST_LOAD_DIR:
   assert property (take && instr_word == {LBAE_OP_LDDIR, LBAE_DIR_PORT_SEL}
      |=> pin_oe_n == $past(acc_value)) else $error("direction load wrong");
   COV_SKIP: cover property (skip_req);
   COV_CLEAR: cover property ($fell(|presc_value));
   COV_LDDIR: cover property ($changed(pin_oe_n));
endmodule
bind lbae_exec lbae_exec_sva #(.NUM_REGS(NUM_REGS)) u_sva (.clk_sys(clk_sys),
   .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
   .presc_to_timer(presc_to_timer), .timer_tick(timer_tick), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n), .acc_value(acc_value),
   .status_value(status_value), .timer_value(timer_value),
   .presc_value(presc_value), .skip_req(skip_req), .exec_busy(exec_busy));
`default_nettype wire

/* File: testbench/lbae_seq_model.sv */
// instruction sequencer model feeding one word per cycle
`default_nettype none
module lbae_seq_model
(
   input wire logic clk_sys,
   output var logic instr_valid,
   output var logic [11:0] instr_word
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      instr_valid = 1'b0;
      instr_word = 12'h000;
   end
   // called after a falling edge; valid stays up for back-to-back words
   task automatic issue(input logic [11:0] w);
      instr_valid = 1'b1;
      instr_word = w;
      @(negedge clk_sys);
   endtask
   // idle word toggles every cycle so a decoder ignoring valid is caught
   task automatic idle(input int n);
      instr_valid = 1'b0;
      repeat (n)
      begin
         instr_word = ~instr_word;
         @(negedge clk_sys);
      end
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the lbae execute stage
`default_nettype none
module tb
   import lbae_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic instr_valid;
   logic [11:0] instr_word;
   logic presc_to_timer = 1'b0;
   logic timer_tick = 1'b0;
   logic [7:0] pin_in = 8'h5A;
   logic [7:0] pin_out, pin_oe_n, acc_value, status_value, timer_value;
   logic [7:0] presc_value, exp_acc, exp_tmr;
   logic skip_req, exec_busy;
   logic [7:0] pv [2] = '{8'h5A, 8'h00};
   logic [11:0] tw [4] = '{12'h661, 12'h761, 12'h7A1, 12'h6A1};
   logic [7:0] km [4] = '{8'hFB, 8'hFB, 8'hBF, 8'hBF};
   logic [3:0] sk = 4'b0101;
   int fails = 0;
   int n_checks = 0;
   always #5 clk_sys = ~clk_sys;
   lbae_seq_model seq (.clk_sys(clk_sys), .instr_valid(instr_valid),
      .instr_word(instr_word));
   lbae_exec #(.NUM_REGS(32)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .presc_to_timer(presc_to_timer), .timer_tick(timer_tick),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .acc_value(acc_value), .status_value(status_value),
      .timer_value(timer_value), .presc_value(presc_value),
      .skip_req(skip_req), .exec_busy(exec_busy));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      chk(pin_oe_n, LBAE_DIR_RESET);
      // second pass: the pins pulled low are read back and clear the latch's 1s
      foreach (pv[i])
      begin
         pin_in = pv[i];
         seq.idle(4);
         seq.issue({LBAE_OP_MOVE, 1'b1, LBAE_ADDR_PORT});
         chk(pin_out, pv[i]);
      end
      pin_in = 8'hC3;
      seq.idle(4);
      seq.issue({LBAE_OP_MOVE, 1'b0, LBAE_ADDR_PORT});
      chk(acc_value, 8'hC3);
      seq.issue({LBAE_OP_LDDIR, LBAE_DIR_PORT_SEL});
      chk(pin_oe_n, 8'hC3);
      exp_tmr = 8'h00;
      for (int b = 7; b >= 0; b--)
      begin
         seq.issue({LBAE_OP_BSET, 3'(b), LBAE_ADDR_TIMER});
         exp_tmr[b] = 1'b1;
         chk(timer_value, exp_tmr);
      end
      for (int b = 0; b < 8; b += 7)
      begin
         seq.issue({LBAE_OP_BCLR, 3'(b), LBAE_ADDR_TIMER});
         exp_tmr[b] = 1'b0;
         chk(timer_value, exp_tmr);
      end
      chk(status_value, 8'h18);
      // a bit op aimed at the status register itself must reach the flag
      seq.issue({LBAE_OP_BSET, 3'(LBAE_ST_ZERO), LBAE_ADDR_STATUS});
      chk(status_value, 8'h1C);
      seq.issue({LBAE_OP_BCLR, 3'(LBAE_ST_ZERO), LBAE_ADDR_STATUS});
      chk(status_value, 8'h18);
      presc_to_timer = 1'b1;
      timer_tick = 1'b1;
      seq.idle(2);
      // a register write in a tick cycle must not cost a prescaler count
      seq.issue({LBAE_OP_BSET, 3'h2, LBAE_ADDR_PORT});
      timer_tick = 1'b0;
      chk(presc_value, 8'h03);
      chk(pin_out, 8'hC7);
      seq.issue({LBAE_OP_ADD, 1'b0, LBAE_ADDR_TIMER});
      chk(acc_value, 8'h44);
      chk(status_value, 8'h19);
      seq.issue({LBAE_OP_AND, 1'b1, LBAE_ADDR_TIMER});
      chk(timer_value, 8'h00);
      chk(presc_value, 8'h00);
      chk(status_value, 8'h1D);
      seq.issue({LBAE_OP_ANDLIT, 8'hFF});
      chk(status_value, 8'h19);
      seq.issue({LBAE_OP_BSET, 3'h5, LBAE_ADDR_TIMER});
      exp_acc = 8'h44;
      // each test is followed at once by a word that a skip must drop
      foreach (tw[i])
      begin
         seq.issue(tw[i]);
         chk({7'h00, skip_req}, {7'h00, sk[i]});
         chk({7'h00, exec_busy}, {7'h00, sk[i]});
         chk(status_value, 8'h19);
         seq.issue({LBAE_OP_ANDLIT, km[i]});
         exp_acc = sk[i] ? exp_acc : exp_acc & km[i];
         chk(acc_value, exp_acc);
      end
      print_verdict();
   end
   // the sequence needs about 55 cycles; 2000 leaves a wide margin
   initial
   begin
      #20000;
      fails++;
      print_verdict();
   end
endmodule
`default_nettype wire
